// ==== core/ecgc_pkg.sv ====
// Constants, types and helpers shared by the echo canceller group control.
// Assumes a 10 MHz system clock and AXI4-Lite register access.
package ecgc_pkg;

    // Clock rate and documented minimum times.
    localparam int CLK_HZ       = 10_000_000;
    localparam int REV_MIN_MS   = 1000;
    localparam int TONE_MIN_MS  = 400;
    localparam int QUIET_MIN_MS = 400;
    localparam int REV_CYC   = REV_MIN_MS * (CLK_HZ / 1000);
    localparam int TONE_CYC  = TONE_MIN_MS * (CLK_HZ / 1000);
    localparam int QUIET_CYC = QUIET_MIN_MS * (CLK_HZ / 1000);
    localparam int CNT_W     = 24;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_GAIN_A = 8'h08;
    localparam logic [7:0] OFS_GAIN_B = 8'h0c;
    localparam logic [7:0] OFS_STAT   = 8'h10;
    localparam logic [7:0] OFS_LAW    = 8'h14;

    // Control register fields.
    localparam int CTRL_W    = 12;
    localparam int B_LONG    = 0;
    localparam int B_DUAL    = 1;
    localparam int B_PAD12   = 2;
    localparam int B_MUTE_R  = 3;
    localparam int B_MUTE_S  = 4;
    localparam int B_BYP     = 5;
    localparam int B_ADIS    = 6;
    localparam int B_PRD     = 7;
    localparam int B_AUTO    = 8;
    localparam int B_NBOFF   = 9;
    localparam int B_DCOFF   = 10;
    localparam int B_OSC     = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

    // Gain fields: three-bit step code, 0 is +9 dB, 7 is -12 dB.
    localparam int G_RIN  = 0;
    localparam int G_SIN  = 4;
    localparam int G_ROUT = 8;
    localparam int G_SOUT = 12;
    localparam logic [15:0] GAIN_RST  = 16'h3333;
    localparam logic [2:0]  GAIN_M12  = 3'h7;
    localparam logic [10:0] PAD_Q8 [8] = '{11'h2d1, 11'h1ff, 11'h16a,
        11'h100, 11'h0b5, 11'h080, 11'h05b, 11'h040};

    // Coding laws and their quiet codes.
    typedef enum logic [1:0] {LAW_LIN, LAW_SM, LAW_MU, LAW_A} ecgc_law_e;
    localparam logic [15:0] Q_LIN = 16'h0000;
    localparam logic [15:0] Q_SM  = 16'h0080;
    localparam logic [15:0] Q_MU  = 16'h00ff;
    localparam logic [15:0] Q_A   = 16'h00d5;

    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // Quiet code for the selected law.
    function automatic logic [15:0] quiet_code(input ecgc_law_e law);
        unique case (law)
            LAW_LIN: quiet_code = Q_LIN;
            LAW_SM:  quiet_code = Q_SM;
            LAW_MU:  quiet_code = Q_MU;
            LAW_A:   quiet_code = Q_A;
        endcase
    endfunction

endpackage

// ==== core/ecgc_tone_if.sv ====
// Carrier between the group control and one pair of tone detectors.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ecgc_tone_if;
    logic tone_rx;
    logic tone_tx;
    logic rev_rx;
    logic rev_tx;
    logic quiet;
    logic mode_g164;
    logic td;
    logic det_p;
    logic rel_p;
    modport ctl (output tone_rx, tone_tx, rev_rx, rev_tx, quiet, mode_g164,
                 input td, det_p, rel_p);
    modport det (input tone_rx, tone_tx, rev_rx, rev_tx, quiet, mode_g164,
                 output td, det_p, rel_p);
endinterface

// ==== core/ecgc_pad.sv ====
// Level pad: scales a linear code by a 3 dB step gain with saturation.
// Assumes companded codes pass unchanged.
`timescale 1ns/1ps
module ecgc_pad (
    input  wire logic [15:0] code_in,
    input  wire logic [2:0]  gain,
    input  wire logic        lin,
    output logic      [15:0] code_out
);
    logic signed [26:0] prod;
    logic signed [18:0] scaled;

    // Multiply in Q8, then clamp to the 16-bit range.
    always_comb begin
        prod   = $signed(code_in) * $signed(ecgc_pkg::PAD_Q8[gain]);
        scaled = prod[26:8];
        if (!lin) begin
            code_out = code_in;
        end else if (scaled > 19'sh07fff) begin
            code_out = 16'h7fff;
        end else if (scaled < -19'sh08000) begin
            code_out = 16'h8000;
        end else begin
            code_out = scaled[15:0];
        end
    end
endmodule // ecgc_pad

// ==== core/ecgc_tone.sv ====
// Disable-tone timing for one canceller: receive and send detectors.
// Assumes tone, reversal and quiet indications from the signal front end.
`timescale 1ns/1ps
module ecgc_tone #(
    parameter int RCYC = ecgc_pkg::REV_CYC,
    parameter int TCYC = ecgc_pkg::TONE_CYC,
    parameter int QCYC = ecgc_pkg::QUIET_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    ecgc_tone_if.det t
);
    localparam int CW = ecgc_pkg::CNT_W;
    logic [1:0]    tone;
    logic [1:0]    rev;
    logic [1:0]    hit;
    logic [CW-1:0] tcnt_r [2];
    logic [1:0]    rseen_r;
    logic [CW-1:0] qcnt_r;
    logic          td_r;
    logic          det_r;
    logic          rel_r;
    logic          qdone;

    assign tone = {t.tone_tx, t.tone_rx};
    assign rev  = {t.rev_tx, t.rev_rx};

    // Trigger on either input; mode picks duration-only or reversal check.
    always_comb begin
        for (int d = 0; d < 2; d++) begin
            hit[d] = t.mode_g164 ? (tcnt_r[d] >= CW'(TCYC - 1))
                : (tcnt_r[d] >= CW'(RCYC - 1) && rseen_r[d]);
        end
    end
    assign qdone = t.quiet && qcnt_r >= CW'(QCYC - 1);

    // Tone duration counters and reversal memory, per input.
    always_ff @(posedge aclk) begin
        for (int d = 0; d < 2; d++) begin
            if (!aresetn || !tone[d]) begin
                tcnt_r[d]  <= '0;
                rseen_r[d] <= 1'b0;
            end else begin
                if (tcnt_r[d] != '1) tcnt_r[d] <= tcnt_r[d] + 1'b1;
                if (rev[d]) rseen_r[d] <= 1'b1;
            end
        end
    end

    // Quiet counter runs only while the flag is held.
    always_ff @(posedge aclk) begin
        if (!aresetn || !td_r || !t.quiet) qcnt_r <= '0;
        else if (!qdone) qcnt_r <= qcnt_r + 1'b1;
    end

    // The flag holds after the tone ends, until quiet lasts long enough.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            td_r  <= 1'b0;
            det_r <= 1'b0;
            rel_r <= 1'b0;
        end else begin
            det_r <= !td_r && |hit;
            rel_r <= td_r && qdone;
            if (!td_r && |hit) td_r <= 1'b1;
            else if (td_r && qdone) td_r <= 1'b0;
        end
    end

    assign t.td    = td_r;
    assign t.det_p = det_r;
    assign t.rel_p = rel_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    release_after_quiet_a: assert property (
        $fell(td_r) |-> $past(qcnt_r) == CW'(QCYC - 1))
        else $error("tone flag released before quiet time");
    trigger_needs_hit_a: assert property (
        $rose(td_r) |-> |$past(hit))
        else $error("tone flag set without a valid tone");
endmodule // ecgc_tone

// ==== core/ecgc_group.sv ====
// Echo canceller group control: two cancellers, register slave, PCM path.
// Assumes AXI4-Lite master on aclk and a frame clock pin from the link.
// Function
// - Reversal mode needs 1 s tone, one reversal.
// - Plain mode triggers after 400 ms tone.
// - Two detectors per channel; set flag, interrupt.
// - Tone flag stays after tone disappears.
// - Release after 400 ms quiet; interrupt again.
// - Mode bit 7 selects plain tone criteria.
// - Automatic mode bypasses on detected tone.
// - Oscillation suppression follows its enable bit.
// - Narrow-band tones halt adaptation, cancellation continues.
// - Narrow-band detector runs unless disabled.
// - DC removal on both inputs unless disabled.
// - Four pads, +9 to -12 dB steps; the pads scale linear codes only, companded codes pass unchanged.
// - Legacy pad forces -12 dB at receive input; takes effect in linear law only, companded codes pass unchanged.
// - Normal mode runs both cancellers in parallel.
// - Dual mode: second timeslot carries quiet code.
// - Long tail cascades pair; second slot quiet.
// - Send_mute insert quiet code in normal, long.
// - Quiet codes 0000, 80, FF, D5 by law.
// - Dual mode: first canceller send_mute outputs.
// - Bypass passes codes, clears coefficients.
`timescale 1ns/1ps
module ecgc_group #(
    parameter int REV_CYC   = ecgc_pkg::REV_CYC,
    parameter int TONE_CYC  = ecgc_pkg::TONE_CYC,
    parameter int QUIET_CYC = ecgc_pkg::QUIET_CYC
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [7:0]       araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    input  wire logic             link_clk,
    input  wire logic [1:0][15:0] rin_code,
    input  wire logic [1:0][15:0] sin_code,
    input  wire logic [1:0][15:0] ec_sout,
    input  wire logic [1:0]       tone_rx,
    input  wire logic [1:0]       tone_tx,
    input  wire logic [1:0]       rev_rx,
    input  wire logic [1:0]       rev_tx,
    input  wire logic [1:0]       quiet_in,
    input  wire logic [1:0]       nb_tone,
    output logic [1:0][15:0]      rout_code,
    output logic [1:0][15:0]      sout_code,
    output logic [1:0][15:0]      ref_code,
    output logic [1:0][15:0]      sin_fil,
    output logic [1:0]            adapt_en,
    output logic [1:0]            coef_clear,
    output logic [1:0]            dc_removal_en,
    output logic [1:0]            osc_suppress_en,
    output logic [1:0]            narrow_band_detector,
    output logic                  long_tail,
    output logic                  dual_direction,
    output logic                  irq_n
);
    localparam int CW = ecgc_pkg::CTRL_W;
    logic [CW-1:0]         ctrl_r [2];
    logic [15:0]           gain_r [2];
    ecgc_pkg::ecgc_law_e   law_r;
    logic [3:0]            pend_r;
    logic [3:0]            pend_nxt;
    logic [7:0]            awaddr_r;
    logic [31:0]           wdata_r;
    logic [3:0]            wstrb_r;
    logic                  wr_go;
    logic [1:0]            td;
    logic [1:0]            det_p;
    logic [1:0]            rel_p;
    logic [2:0]            lsync_r;
    logic                  frame_tick;
    logic                  b2b;
    logic                  ext;
    logic [1:0]            byp;
    logic [15:0]           q;
    logic [15:0]           pin  [2][4];
    logic [2:0]            pg   [2][4];
    logic [15:0]           pout [2][4];
    logic [1:0][15:0]      rout_nxt;
    logic [1:0][15:0]      sout_nxt;
    logic [1:0][15:0]      ref_nxt;
    logic [1:0]            adapt_nxt;
    logic [32:0]           wr_map;
    logic [32:0]           rd_map;
    logic [31:0]           wr_word;

    // Byte-lane merge of a write into an old register value.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // Read value and mapping check for a byte address.
    function automatic logic [32:0] rd_word(input logic [7:0] a);
        rd_word = '0;
        unique case (a)
            ecgc_pkg::OFS_CTRL_A: rd_word = {1'b1, 20'h0, ctrl_r[0]};
            ecgc_pkg::OFS_CTRL_B: rd_word = {1'b1, 20'h0, ctrl_r[1]};
            ecgc_pkg::OFS_GAIN_A: rd_word = {1'b1, 16'h0, gain_r[0]};
            ecgc_pkg::OFS_GAIN_B: rd_word = {1'b1, 16'h0, gain_r[1]};
            ecgc_pkg::OFS_STAT:   rd_word = {1'b1, 19'h0, ~irq_n, pend_r,
                                     2'h0, adapt_en, coef_clear, td};
            ecgc_pkg::OFS_LAW:    rd_word = {1'b1, 30'h0, law_r};
            default:              rd_word = '0;
        endcase
    endfunction

    // Decode of the pending write and the offered read, with lane merge.
    always_comb begin
        wr_map  = rd_word(awaddr_r);
        rd_map  = rd_word(araddr);
        wr_word = merge(wr_map[31:0], wdata_r, wstrb_r);
    end

    // Frame clock pin: two synchroniser stages, then edge detection.
    always_ff @(posedge aclk) begin
        if (!aresetn) lsync_r <= 3'h0;
        else lsync_r <= {lsync_r[1:0], link_clk};
    end
    assign frame_tick = lsync_r[1] && !lsync_r[2];

    // Write address and data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b1;
            wready   <= 1'b1;
            bvalid   <= 1'b0;
            bresp    <= ecgc_pkg::RESP_OK;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0;
            wstrb_r  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready  <= 1'b0;
                awaddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wready  <= 1'b0;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_map[32] ? ecgc_pkg::RESP_OK : ecgc_pkg::RESP_ERR;
            end else if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end
    assign wr_go = !awready && !wready && !bvalid;

    // Configuration registers written by software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r[0] <= ecgc_pkg::CTRL_RST;
            ctrl_r[1] <= ecgc_pkg::CTRL_RST;
            gain_r[0] <= ecgc_pkg::GAIN_RST;
            gain_r[1] <= ecgc_pkg::GAIN_RST;
            law_r     <= ecgc_pkg::LAW_LIN;
        end else if (wr_go) begin
            unique case (awaddr_r)
                ecgc_pkg::OFS_CTRL_A: ctrl_r[0] <= wr_word[CW-1:0];
                ecgc_pkg::OFS_CTRL_B: ctrl_r[1] <= wr_word[CW-1:0];
                ecgc_pkg::OFS_GAIN_A: gain_r[0] <= wr_word[15:0];
                ecgc_pkg::OFS_GAIN_B: gain_r[1] <= wr_word[15:0];
                ecgc_pkg::OFS_LAW:
                    law_r <= ecgc_pkg::ecgc_law_e'(wr_word[1:0]);
                default: ;
            endcase
        end
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= ecgc_pkg::RESP_OK;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_map[31:0];
            rresp   <= rd_map[32] ? ecgc_pkg::RESP_OK : ecgc_pkg::RESP_ERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Sticky detect and release events; a new event beats a clear.
    always_comb begin
        pend_nxt = pend_r;
        if (wr_go && awaddr_r == ecgc_pkg::OFS_STAT && wstrb_r[0])
            pend_nxt = pend_r & ~wdata_r[7:4];
        pend_nxt = pend_nxt | {rel_p, det_p};
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= 4'h0;
            irq_n  <= 1'b1;
        end else begin
            pend_r <= pend_nxt;
            irq_n  <= ~|pend_r;
        end
    end

    // Two tone detectors for each canceller.
    for (genvar c = 0; c < 2; c++) begin : g_tone
        ecgc_tone_if tif ();
        assign tif.tone_rx   = tone_rx[c];
        assign tif.tone_tx   = tone_tx[c];
        assign tif.rev_rx    = rev_rx[c];
        assign tif.rev_tx    = rev_tx[c];
        assign tif.quiet     = quiet_in[c];
        assign tif.mode_g164 = ctrl_r[c][ecgc_pkg::B_PRD];
        assign td[c]         = tif.td;
        assign det_p[c]      = tif.det_p;
        assign rel_p[c]      = tif.rel_p;
        ecgc_tone #(
            .RCYC (REV_CYC),
            .TCYC (TONE_CYC),
            .QCYC (QUIET_CYC)
        ) u_tone (
            .aclk    (aclk),
            .aresetn (aresetn),
            .t       (tif.det)
        );
    end

    // Group configuration and per-canceller bypass state.
    assign b2b = ctrl_r[0][ecgc_pkg::B_DUAL]
              && ctrl_r[1][ecgc_pkg::B_DUAL];
    assign ext = ctrl_r[0][ecgc_pkg::B_LONG] && !b2b;
    assign q   = ecgc_pkg::quiet_code(law_r);
    for (genvar c = 0; c < 2; c++) begin : g_byp
        assign byp[c] = ctrl_r[c][ecgc_pkg::B_BYP]
            || (ctrl_r[c][ecgc_pkg::B_AUTO] && td[c]);
    end
    // Four level pads per canceller.
    for (genvar c = 0; c < 2; c++) begin : g_pad
        assign pin[c][0] = rin_code[c];
        assign pin[c][1] = sin_code[c];
        assign pin[c][2] = pout[c][0];
        assign pin[c][3] = ec_sout[c];
        assign pg[c][0]  = ctrl_r[c][ecgc_pkg::B_PAD12] ? ecgc_pkg::GAIN_M12
            : gain_r[c][ecgc_pkg::G_RIN +: 3];
        assign pg[c][1]  = gain_r[c][ecgc_pkg::G_SIN +: 3];
        assign pg[c][2]  = gain_r[c][ecgc_pkg::G_ROUT +: 3];
        assign pg[c][3]  = gain_r[c][ecgc_pkg::G_SOUT +: 3];
        for (genvar k = 0; k < 4; k++) begin : g_port
            ecgc_pad u_pad (
                .code_in  (pin[c][k]),
                .gain     (pg[c][k]),
                .lin      (law_r == ecgc_pkg::LAW_LIN),
                .code_out (pout[c][k])
            );
        end
    end
    // Output code selection: silent slot, bypass, mute, padded path.
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ref_nxt[c] = (ctrl_r[c][ecgc_pkg::B_MUTE_R] && !b2b) ? q
                : pout[c][0];
            if (c == 1 && (b2b || ext)) begin
                rout_nxt[c] = q;
                sout_nxt[c] = q;
            end else if (byp[c]) begin
                rout_nxt[c] = rin_code[c];
                sout_nxt[c] = sin_code[c];
            end else begin
                rout_nxt[c] = ctrl_r[c][ecgc_pkg::B_MUTE_R] ? q
                    : pout[c][2];
                sout_nxt[c] = ctrl_r[c][ecgc_pkg::B_MUTE_S] ? q
                    : pout[c][3];
            end
            adapt_nxt[c] = !byp[c] && !ctrl_r[c][ecgc_pkg::B_ADIS]
                && !(nb_tone[c] && !ctrl_r[c][ecgc_pkg::B_NBOFF]);
        end
    end

    // PCM outputs change once per frame.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rout_code <= '0;
            sout_code <= '0;
            ref_code  <= '0;
            sin_fil   <= '0;
        end else if (frame_tick) begin
            rout_code <= rout_nxt;
            sout_code <= sout_nxt;
            ref_code  <= ref_nxt;
            sin_fil   <= {pout[1][1], pout[0][1]};
        end
    end

    // Control levels for the filter core of each canceller.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adapt_en             <= 2'h0;
            coef_clear           <= 2'h0;
            dc_removal_en        <= 2'h0;
            osc_suppress_en      <= 2'h0;
            narrow_band_detector <= 2'h0;
            long_tail            <= 1'b0;
            dual_direction       <= 1'b0;
        end else begin
            adapt_en   <= adapt_nxt;
            coef_clear <= byp;
            for (int c = 0; c < 2; c++) begin
                dc_removal_en[c]   <= !ctrl_r[c][ecgc_pkg::B_DCOFF];
                osc_suppress_en[c] <= ctrl_r[c][ecgc_pkg::B_OSC];
                narrow_band_detector[c] <=
                    !ctrl_r[c][ecgc_pkg::B_NBOFF];
            end
            long_tail      <= ext;
            dual_direction <= b2b;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    detect_irq_a: assert property ($rose(td[0]) |-> ##2 !irq_n)
        else $error("no interrupt after tone detection");
    auto_bypass_a: assert property (
        ctrl_r[0][ecgc_pkg::B_AUTO] && td[0] |=> coef_clear[0])
        else $error("automatic bypass not taken");
    sout_mute_a: assert property (
        frame_tick && ctrl_r[0][ecgc_pkg::B_MUTE_S] && !byp[0]
        |=> sout_code[0] == $past(q))
        else $error("send mute did not insert quiet code");
    second_slot_a: assert property (
        frame_tick && (b2b || ext) |=> rout_code[1] == $past(q)
        && sout_code[1] == $past(q))
        else $error("second timeslot not quiet");
    nb_halt_a: assert property (
        nb_tone[0] && !ctrl_r[0][ecgc_pkg::B_NBOFF] |=> !adapt_en[0])
        else $error("adaptation not halted on narrow band");
    bypass_pass_a: assert property (
        frame_tick && byp[0] |=> rout_code[0] == $past(rin_code[0]))
        else $error("bypass did not pass receive code");
    quiet_law_a: assert property (
        law_r == ecgc_pkg::LAW_A |-> q == 16'h00d5)
        else $error("wrong quiet code for A-law");
    detect_c: cover property ($rose(td[0]));
    release_c: cover property ($fell(td[1]));
    dual_c: cover property (frame_tick && b2b);
    long_c: cover property (frame_tick && ext && byp[0]);
endmodule // ecgc_group

// ==== verif/ecgc_far.sv ====
// Far-side model: free-running frame clock and PCM codes for both slots.
// Assumes the bench connects it to the group control by name.
`timescale 1ns/1ps
module ecgc_far (
    output logic             link_clk,
    output logic [1:0][15:0] rin_code,
    output logic [1:0][15:0] sin_code
);
    // Frame clock of 800 ns; the codes step at each frame start.
    initial begin
        link_clk = 1'b0;
        rin_code = '0;
        sin_code = '0;
        forever begin
            #400 link_clk = ~link_clk;
            if (link_clk) begin
                rin_code = rin_code + 32'h0001_0203;
                sin_code = sin_code + 32'h0101_0101;
            end
        end
    end
endmodule // ecgc_far

// ==== verif/testbench.sv ====
// Bench for the group control: registers, tone timing, send_mute and modes.
// Assumes the far-side model drives the frame clock and PCM inputs.
`timescale 1ns/1ps
module testbench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, link_clk;
    logic awready, wready, bvalid, arready, rvalid, long_tail;
    logic dual_direction, irq_n;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, st;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr, tone_rx, tone_tx, rev_rx, rev_tx;
    logic [1:0] quiet_in, nb_tone, adapt_en, coef_clear, dc_removal_en;
    logic [1:0] osc_suppress_en, narrow_band_detector;
    logic [1:0][15:0] rin_code, sin_code, ec_sout, rout_code, sout_code;
    logic [1:0][15:0] ref_code, sin_fil;
    logic [17:0] rows [4] = '{{2'h0, 16'h0000}, {2'h1, 16'h0080},
        {2'h2, 16'h00ff}, {2'h3, 16'h00d5}};
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;

    ecgc_group #(.REV_CYC(40), .TONE_CYC(16), .QUIET_CYC(16)) u_dut (.*);
    ecgc_far u_far (.*);

    // Clock of 100 ns.
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Watchdog cuts a hang short.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Write one word; address and data are released as each is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, 2'h0);
    endtask

    // Read one word and its response code.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Main sequence: reset, mute table, then tone and mode cases.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, ec_sout} = '0;
        wstrb = 4'hf;
        {tone_rx, tone_tx, rev_rx, rev_tx, quiet_in, nb_tone} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h08, st, rr);
        chk(st, 32'h3333);
        rd(8'h18, st, rr);
        chk(rr, 2'h2);
        chk(irq_n, 1'b1);
        chk(adapt_en, 2'h3);
        chk(dc_removal_en, 2'h3);
        chk(narrow_band_detector, 2'h3);
        chk({long_tail, dual_direction, coef_clear, osc_suppress_en},
            6'h00);
        @(negedge link_clk);
        chk(rout_code[0], rin_code[0]);
        chk(ref_code[0], rin_code[0]);
        chk(sin_fil[0], sin_code[0]);
        wr(8'h04, 32'he00);
        nb_tone <= 2'b11;
        repeat (2) @(posedge aclk);
        chk(adapt_en, 2'h2);
        chk(osc_suppress_en, 2'h2);
        chk(dc_removal_en, 2'h1);
        chk(narrow_band_detector, 2'h1);
        nb_tone <= 2'b00;
        wr(8'h00, 32'h4);
        repeat (2) @(negedge link_clk);
        chk(rout_code[0], rin_code[0] >> 2);
        wr(8'h00, 32'h18);
        foreach (rows[i]) begin
            wr(8'h14, {30'h0, rows[i][17:16]});
            repeat (24) @(posedge aclk);
            chk(rout_code[0], rows[i][15:0]);
            chk(sout_code[0], rows[i][15:0]);
            chk(ref_code[0], rows[i][15:0]);
        end
        wr(8'h00, 32'h180);
        tone_rx <= 2'b11;
        repeat (25) @(posedge aclk);
        rd(8'h10, st, rr);
        chk(st & 32'h1303, 32'h1101);
        chk(irq_n, 1'b0);
        chk(coef_clear[0], 1'b1);
        tone_rx[0] <= 1'b0;
        rev_rx[1] <= 1'b1;
        @(posedge aclk);
        rev_rx[1] <= 1'b0;
        repeat (45) @(posedge aclk);
        wr(8'h10, 32'h30);
        rd(8'h10, st, rr);
        chk(st & 32'h1303, 32'h0003);
        wr(8'h04, 32'he20);
        @(posedge aclk);
        chk(coef_clear[1], 1'b1);
        quiet_in <= 2'b01;
        repeat (25) @(posedge aclk);
        rd(8'h10, st, rr);
        chk(st & 32'h1503, 32'h1402);
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h2);
        repeat (24) @(posedge aclk);
        chk(dual_direction, 1'b1);
        chk(sout_code[1], 16'h00d5);
        chk(rout_code[1], 16'h00d5);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        repeat (24) @(posedge aclk);
        chk(long_tail, 1'b1);
        chk(rout_code[1], 16'h00d5);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({irq_n, long_tail}, 2'h2);
        aresetn <= 1'b1;
        rd(8'h00, st, rr);
        chk(st, 32'h0);
        end_sim();
    end
endmodule // testbench
